/* rtl/phs_pkg.sv */
package phs_pkg;
  // clock and half-millisecond time base
  localparam int CLK_KHZ        = 25000;   // 25 MHz system clock
  localparam int HALF_MS_US     = 500;     // sequencer timer unit
  localparam int HALF_MS_CYC    = HALF_MS_US * CLK_KHZ / 1000;
  localparam int TURNOFF_MAX_US = 10;      // reset assert to first rail off
  localparam int TURNOFF_CYC    = TURNOFF_MAX_US * CLK_KHZ / 1000;
  localparam int FAULT_WAIT_MS  = 100;     // post-fault wait before restart
  localparam int WAKE_PULSE_MS  = 25;      // automatic wake pulse length
  localparam int RETRY_MS       = 32;      // grace time for a slow rail
  localparam int FAULT_UNITS    = FAULT_WAIT_MS * 1000 / HALF_MS_US;
  localparam int WAKE_UNITS     = WAKE_PULSE_MS * 1000 / HALF_MS_US;
  localparam int RETRY_UNITS    = RETRY_MS * 1000 / HALF_MS_US;

  // register offsets (byte addresses, one word each)
  localparam logic [3:0] ADDR_SEQ  = 4'h0;
  localparam logic [3:0] ADDR_RAIL = 4'h4;
  localparam logic [3:0] ADDR_VOUT = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hc;

  // highest output voltage code for every channel
  localparam logic [5:0] VOUT_MAX_CODE = 6'h32;
  localparam logic [2:0] RESET_RELEASE_DELAY_16MS   = 3'h4;

  // sequencing word: slots, step delays, reset delay, misc
  typedef struct packed {
    logic [11:0]      rsvd;
    logic             hystEnable;    // first channel hysteretic control
    logic             wakeDisable;   // suppress automatic wake pulse
    logic [2:0]       rstDelaySel;   // 1 ms << sel
    logic [2:0][2:0]  stepDelay;     // per channel delay code
    logic [2:0][1:0]  seqSlot;       // 1..3, 0 leaves the channel out
  } phs_seq_t;

  // per channel enables and switching styles per power state
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] phase;     // 180 degree shifted switching
    logic [2:0] disch;     // active discharge while off
    logic [2:0] hiccup;    // hiccup protection on short circuit
    logic [2:0] pwmHib;    // forced_pwm in hibernate
    logic [2:0] pwmLp;     // forced_pwm in low power
    logic [2:0] pwmAct;    // forced_pwm in active
    logic [2:0] enHib;
    logic [2:0] enLp;
    logic [2:0] enAct;
  } phs_rail_cfg_t;

  // output voltage codes and soft-start rates
  typedef struct packed {
    logic [7:0]      rsvd;
    logic [2:0][1:0] ssr;    // 0: 3.125, 1: 1.563, 2: 1.042, 3: 0.781 V/ms
    logic [2:0][5:0] vout;   // steps above each channel's floor
  } phs_vout_t;

  // rail drive towards the power stages
  typedef struct packed {
    logic [2:0] en;
    logic [2:0] pwm;
    logic [2:0] dis;
  } phs_rails_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } phs_bus_t;

  typedef enum logic [3:0] {
    S_OFF      = 4'h0,
    S_STEP_DLY = 4'h1,
    S_STEP_PG  = 4'h2,
    S_RST_DLY  = 4'h3,
    S_ACTIVE   = 4'h4,
    S_LOWPWR   = 4'h5,
    S_GOING_DN = 4'h6,
    S_HIBER    = 4'h7,
    S_FAULT    = 4'h8
  } phs_state_t;

  localparam phs_seq_t SEQ_RST = '{rsvd: 12'h000, hystEnable: 1'b0,
    wakeDisable: 1'b0, rstDelaySel: RESET_RELEASE_DELAY_16MS,
    stepDelay: {3'h4, 3'h5, 3'h1}, seqSlot: {2'h3, 2'h2, 2'h1}};
  localparam phs_rail_cfg_t RAIL_RST = '{rsvd: 5'h00, phase: 3'h5,
    disch: 3'h7, hiccup: 3'h7, pwmHib: 3'h0, pwmLp: 3'h0, pwmAct: 3'h7,
    enHib: 3'h2, enLp: 3'h7, enAct: 3'h7};
  localparam phs_vout_t VOUT_RST = '{rsvd: 8'h00, ssr: {2'h0, 2'h0, 2'h0},
    vout: {6'h16, 6'h1e, 6'h2a}};
endpackage

/* rtl/phs_sequencer.sv */
// How it works
// - lpr before hold drop enters hibernate
// - rails start off within ten microseconds
// - hibernate, lpr falls, hold low: off
// - hold rising in hibernate restarts, skip live rails
// - lpr may drop anytime after hold rises
// - kept rail stays pulse-skip until reset release
// - fault: all off, wait 100 ms, restart
// - fault in hibernate: 25 ms echo wake pulse
// - wake pulse lies inside the 100 ms wait
// - echo follows start input otherwise
// - reset released only with power hold high
// - lpr high after restart: enter low power
// - no wake pulse outside hibernate faults
// - wake pulse can be disabled, default on
// - reset delay 1 to 128 ms, default 16
// - per channel output voltage codes
// - per state enable and pwm choice
// - four soft-start rates, default fastest
// - per channel slot and step delay
// - no hiccup: short stops all, restarts
// - discharge while a channel is off
// - per channel 180 degree phase
// - first channel hysteretic control enable
module phs_sequencer #(
  parameter int HALF_MS_CYC_P = phs_pkg::HALF_MS_CYC  // cycles per 0.5 ms
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // register port
  input  wire phs_pkg::phs_bus_t    busReq,
  output logic [31:0]               readData,
  // processor handshake pins
  input  wire logic                 startInN,
  input  wire logic                 powerHold,
  input  wire logic                 lowPowerRequest,
  output logic                      resetOutN,
  output logic                      startEchoOutN,
  // power stage status
  input  wire logic [2:0]           railGood,
  input  wire logic [2:0]           railShort,
  input  wire logic                 faultIn,
  // power stage control
  output phs_pkg::phs_rails_t       rails,
  output phs_pkg::phs_vout_t        voutCfg,
  output logic [2:0]                phaseSel,
  output logic                      hystEnable
);
  import phs_pkg::*;

  localparam int OFF_MAX_CYC = TURNOFF_CYC;  // assertion bound

  // the prescaler is 16 bits wide
  if (HALF_MS_CYC_P < 2 || HALF_MS_CYC_P > 65535) begin : g_chk
    $error("HALF_MS_CYC_P out of range");
  end

  // step delay code to half-millisecond units
  function automatic logic [8:0] dlyUnits(input logic [2:0] code);
    case (code)
      3'h0:    dlyUnits = 9'h000;
      3'h1:    dlyUnits = 9'h001;
      3'h2:    dlyUnits = 9'h002;
      3'h3:    dlyUnits = 9'h004;
      3'h4:    dlyUnits = 9'h008;
      3'h5:    dlyUnits = 9'h010;
      3'h6:    dlyUnits = 9'h018;
      default: dlyUnits = 9'h020;
    endcase
  endfunction

  // saturate a written voltage code to the top of the range
  function automatic logic [5:0] clampCode(input logic [5:0] code);
    clampCode = (code > VOUT_MAX_CODE) ? VOUT_MAX_CODE : code;
  endfunction

  // ---------------- input synchronisers ----------------
  logic [9:0] syncA_reg, syncA_next;  // first stage, read only by stage two
  logic [9:0] syncB_reg, syncB_next;  // second stage, safe to use
  logic       phPrev_reg, phPrev_next;
  logic       startS, phS, lprS, faultS;
  logic [2:0] goodS, shortS;

  // two flops on every pin before any logic sees it
  always_comb begin
    syncA_next  = {startInN, powerHold, lowPowerRequest, railGood,
                   railShort, faultIn};
    syncB_next  = syncA_reg;
    phPrev_next = syncB_reg[8];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA_reg  <= 10'h200;
      syncB_reg  <= 10'h200;
      phPrev_reg <= 1'b0;
    end else begin
      syncA_reg  <= syncA_next;
      syncB_reg  <= syncB_next;
      phPrev_reg <= phPrev_next;
    end
  end

  assign startS = syncB_reg[9];
  assign phS    = syncB_reg[8];
  assign lprS   = syncB_reg[7];
  assign goodS  = syncB_reg[6:4];
  assign shortS = syncB_reg[3:1];
  assign faultS = syncB_reg[0];

  // ---------------- configuration registers ----------------
  phs_seq_t      seq_reg, seq_next;
  phs_rail_cfg_t rail_reg, rail_next;
  phs_vout_t     vout_reg, vout_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic [31:0]   statWord;          // live status word
  phs_vout_t     wrVout;            // write data seen as voltage word

  // decode writes; a read answers in the next cycle only
  always_comb begin
    seq_next   = seq_reg;
    rail_next  = rail_reg;
    vout_next  = vout_reg;
    rdata_next = 32'h0000_0000;
    wrVout     = phs_vout_t'(busReq.wdata);
    if (busReq.we) begin
      case (busReq.addr)
        ADDR_SEQ: begin
          seq_next      = phs_seq_t'(busReq.wdata);
          seq_next.rsvd = '0;
        end
        ADDR_RAIL: begin
          rail_next      = phs_rail_cfg_t'(busReq.wdata);
          rail_next.rsvd = '0;
        end
        ADDR_VOUT: begin
          vout_next.ssr = wrVout.ssr;
          for (int i = 0; i < 3; i++) begin
            vout_next.vout[i] = clampCode(wrVout.vout[i]);
          end
        end
        default: ;  // status and unmapped: writes ignored
      endcase
    end
    if (busReq.re) begin
      case (busReq.addr)
        ADDR_SEQ:  rdata_next = seq_reg;
        ADDR_RAIL: rdata_next = rail_reg;
        ADDR_VOUT: rdata_next = vout_reg;
        ADDR_STAT: rdata_next = statWord;
        default:   rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_reg   <= SEQ_RST;
      rail_reg  <= RAIL_RST;
      vout_reg  <= VOUT_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      seq_reg   <= seq_next;
      rail_reg  <= rail_next;
      vout_reg  <= vout_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------- sequencer ----------------
  phs_state_t state_reg, state_next;
  logic [1:0]  slot_reg, slot_next;        // current sequence step
  logic [2:0]  railOn_reg, railOn_next;    // rails commanded on
  logic [2:0]  kept_reg, kept_next;        // rails left up by hibernate
  logic        restart_reg, restart_next;  // sequence launched by fault
  logic        faultHib_reg, faultHib_next;
  logic        hibTgt_reg, hibTgt_next;    // going down into hibernate
  logic        rstN_reg, rstN_next;
  logic        echo_reg, echo_next;
  logic        wakeLow;                    // wake pulse window
  phs_rails_t  rails_reg, rails_next;
  logic [15:0] presc_reg, presc_next;
  logic [8:0]  tmr_reg, tmr_next;          // half-millisecond units
  logic        halfTick, tmrClr, phRise, faultQual;
  logic [2:0]  stepMask, stateMask;
  logic [8:0]  stepDly, rstUnits;

  assign phRise = phS & ~phPrev_reg;
  // a short on a channel without hiccup behaves like a hard fault
  assign faultQual = faultS | (|(shortS & ~rail_reg.hiccup));
  assign halfTick  = (presc_reg == 16'(HALF_MS_CYC_P - 1));
  assign rstUnits  = 9'h002 << seq_reg.rstDelaySel;

  // channels in this slot not yet running; slot 0 is never started
  always_comb begin
    stepMask = '0;
    stepDly  = '0;
    for (int i = 2; i >= 0; i--) begin
      if (seq_reg.seqSlot[i] == slot_reg && rail_reg.enAct[i] &&
          !railOn_reg[i]) begin
        stepMask[i] = 1'b1;
        stepDly     = dlyUnits(seq_reg.stepDelay[i]);
      end
    end
  end

  // next state of the power state machine
  always_comb begin
    state_next    = state_reg;
    slot_next     = slot_reg;
    railOn_next   = railOn_reg;
    kept_next     = kept_reg;
    restart_next  = restart_reg;
    faultHib_next = faultHib_reg;
    hibTgt_next   = hibTgt_reg;
    rstN_next     = rstN_reg;
    case (state_reg)
      S_OFF: begin
        railOn_next = '0;
        if (!startS || phRise) begin
          state_next   = S_STEP_DLY;
          slot_next    = 2'h1;
          restart_next = 1'b0;
          kept_next    = '0;
        end
      end
      S_STEP_DLY: begin
        if (stepMask == '0) begin
          if (slot_reg == 2'h3) state_next = S_RST_DLY;
          else slot_next = slot_reg + 2'h1;
        end else if (tmr_reg >= stepDly) begin
          // first step needs a still valid start event
          if (slot_reg == 2'h1 && !restart_reg && !phS && startS) begin
            state_next = S_OFF;
          end else begin
            railOn_next = railOn_reg | stepMask;
            state_next  = S_STEP_PG;
          end
        end
      end
      S_STEP_PG: begin
        if ((goodS & railOn_reg) == railOn_reg) begin
          if (slot_reg == 2'h3) begin
            state_next = S_RST_DLY;
          end else begin
            slot_next  = slot_reg + 2'h1;
            state_next = S_STEP_DLY;
          end
        end else if (tmr_reg >= 9'(RETRY_UNITS)) begin
          state_next  = S_OFF;   // rail never came up: give up
          railOn_next = '0;
        end
      end
      S_RST_DLY: begin
        if (tmr_reg >= rstUnits) begin
          if (phS) begin
            rstN_next  = 1'b1;
            kept_next  = '0;
            state_next = lprS ? S_LOWPWR : S_ACTIVE;
          end else begin
            state_next  = S_OFF;
            railOn_next = '0;
          end
        end
      end
      S_ACTIVE, S_LOWPWR: begin
        if (!phS) begin
          rstN_next   = 1'b0;
          hibTgt_next = lprS;
          state_next  = S_GOING_DN;
        end else begin
          state_next = lprS ? S_LOWPWR : S_ACTIVE;
        end
      end
      S_GOING_DN: begin
        // rails drop one cycle after the reset output falls
        railOn_next = hibTgt_reg ? (railOn_reg & rail_reg.enHib) : '0;
        state_next  = hibTgt_reg ? S_HIBER : S_OFF;
      end
      S_HIBER: begin
        if (!lprS && !phS) begin
          state_next  = S_OFF;
          railOn_next = '0;
        end else if (phRise) begin
          state_next   = S_STEP_DLY;
          slot_next    = 2'h1;
          kept_next    = railOn_reg;
          restart_next = 1'b0;
        end
      end
      S_FAULT: begin
        if (tmr_reg >= 9'(FAULT_UNITS)) begin
          state_next   = S_STEP_DLY;
          slot_next    = 2'h1;
          restart_next = 1'b1;
          kept_next    = '0;
        end
      end
      default: state_next = S_OFF;
    endcase
    // a fault overrides any powered state
    if (faultQual && state_reg != S_OFF && state_reg != S_FAULT) begin
      state_next    = S_FAULT;
      railOn_next   = '0;
      rstN_next     = 1'b0;
      faultHib_next = (state_reg == S_HIBER) && !seq_reg.wakeDisable;
    end
  end

  // timer restarts whenever the state or step moves on
  always_comb begin
    tmrClr     = (state_next != state_reg) || (slot_next != slot_reg);
    presc_next = (tmrClr || halfTick) ? 16'h0000 : presc_reg + 16'h0001;
    if (tmrClr) tmr_next = 9'h000;
    else if (halfTick && tmr_reg != 9'h1ff) tmr_next = tmr_reg + 9'h001;
    else tmr_next = tmr_reg;
  end

  // outputs computed from next values so every pin is a flop
  always_comb begin
    // wake pulse occupies the tail of the fault wait
    wakeLow = (state_next == S_FAULT) && faultHib_next &&
              (tmr_reg >= 9'(FAULT_UNITS - WAKE_UNITS));
    echo_next = wakeLow ? 1'b0 : startS;
    case (state_next)
      S_ACTIVE: stateMask = rail_reg.enAct;
      S_LOWPWR: stateMask = rail_reg.enLp;
      default:  stateMask = 3'h7;
    endcase
    rails_next.en = railOn_next & stateMask;
    case (state_next)
      S_ACTIVE: rails_next.pwm = rail_reg.pwmAct;
      S_LOWPWR: rails_next.pwm = rail_reg.pwmLp;
      S_HIBER, S_GOING_DN: rails_next.pwm = rail_reg.pwmHib;
      default: rails_next.pwm = (rail_reg.pwmAct & ~kept_next) |
                                (rail_reg.pwmHib & kept_next);
    endcase
    rails_next.dis = rail_reg.disch & ~rails_next.en;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg    <= S_OFF;
      slot_reg     <= 2'h1;
      railOn_reg   <= '0;
      kept_reg     <= '0;
      restart_reg  <= 1'b0;
      faultHib_reg <= 1'b0;
      hibTgt_reg   <= 1'b0;
      rstN_reg     <= 1'b0;
      echo_reg     <= 1'b1;
      rails_reg    <= '{en: 3'h0, pwm: 3'h0, dis: 3'h7};
      presc_reg    <= 16'h0000;
      tmr_reg      <= 9'h000;
    end else begin
      state_reg    <= state_next;
      slot_reg     <= slot_next;
      railOn_reg   <= railOn_next;
      kept_reg     <= kept_next;
      restart_reg  <= restart_next;
      faultHib_reg <= faultHib_next;
      hibTgt_reg   <= hibTgt_next;
      rstN_reg     <= rstN_next;
      echo_reg     <= echo_next;
      rails_reg    <= rails_next;
      presc_reg    <= presc_next;
      tmr_reg      <= tmr_next;
    end
  end

  // status word: state, rail enables, handshake pins
  assign statWord = {23'h000000, echo_reg, rstN_reg, rails_reg.en,
                     state_reg};

  // port drive, all from flops
  assign readData      = rdata_reg;
  assign resetOutN     = rstN_reg;
  assign startEchoOutN = echo_reg;
  assign rails         = rails_reg;
  assign voutCfg       = vout_reg;
  assign phaseSel      = rail_reg.phase;
  assign hystEnable    = seq_reg.hystEnable;

  // ---------------- checks ----------------
  logic [31:0] faultCyc;  // cycles spent in the fault wait
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) faultCyc <= '0;
    else if (state_reg == S_FAULT) faultCyc <= faultCyc + 32'h1;
    else faultCyc <= '0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_hib_keeps_rails: assert property ((state_reg == S_GOING_DN &&
      hibTgt_reg && !faultQual) |=> state_reg == S_HIBER &&
      (rails.en & ~rail_reg.enHib) == 3'h0)
    else $error("hibernate entry left a rail on");
  a_turnoff_bound: assert property ($fell(resetOutN) |->
      ##[0:OFF_MAX_CYC] ((rails.en & ~rail_reg.enHib) == 3'h0))
    else $error("rails not off soon after reset");
  a_hib_to_off: assert property ((state_reg == S_HIBER && !lprS &&
      !phS && !faultQual) |=> state_reg == S_OFF ##1 rails.en == 3'h0)
    else $error("hibernate did not go off");
  a_hib_wake_start: assert property ((state_reg == S_HIBER && phRise
      && (lprS || phS) && !faultQual) |=> state_reg == S_STEP_DLY &&
      kept_reg == $past(railOn_reg))
    else $error("hibernate exit not started");
  a_fault_stops_all: assert property ((faultQual &&
      state_reg != S_OFF && state_reg != S_FAULT) |=>
      rails.en == 3'h0 && !resetOutN && state_reg == S_FAULT)
    else $error("fault did not stop rails");
  a_fault_wait_len: assert property ((state_reg == S_FAULT &&
      state_next != S_FAULT && !faultQual) |->
      faultCyc >= FAULT_UNITS * HALF_MS_CYC_P)
    else $error("fault wait too short");
  a_echo_follows: assert property ((startEchoOutN != $past(startS)) |->
      state_reg == S_FAULT && faultHib_reg)
    else $error("echo differs outside wake pulse");
  a_release_hold: assert property ($rose(resetOutN) |->
      $past(phS) && $past(state_reg) == S_RST_DLY)
    else $error("reset released without hold");
  a_lowpwr_after: assert property (($rose(resetOutN) && $past(lprS))
      |-> state_reg == S_LOWPWR)
    else $error("low power not entered");
  a_no_pulse_awake: assert property ((state_reg == S_FAULT &&
      !faultHib_reg) |-> startEchoOutN == $past(startS))
    else $error("wake pulse outside hibernate");
  a_discharge_off: assert property (($fell(rails.en[0]) &&
      rail_reg.disch[0]) |-> rails.dis[0])
    else $error("discharge not active");

  c_enter_hib: cover property (state_reg == S_GOING_DN ##1
      state_reg == S_HIBER);
  c_wake_pulse: cover property ($fell(startEchoOutN) && state_reg == S_FAULT);
  c_hib_exit: cover property (state_reg == S_HIBER ##1
      state_reg == S_STEP_DLY);
  c_restart_lp: cover property ($rose(resetOutN) && state_reg == S_LOWPWR);
endmodule // phs_sequencer

/* testbench/phs_proc_model.sv */
// processor wake controller as seen from the sequencer pins
module phs_proc_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // commands from the bench
  input  wire logic       sleepReq,  // enter hibernate
  input  wire logic       offReq,    // full power down
  input  wire logic       wakeReq,   // own wake-up event
  input  wire logic       keepLpr,   // leave low power request up on wake
  input  wire logic [7:0] lag,       // answer delay after the echo falls
  // device pins
  input  wire logic       startEchoOutN,
  output logic            powerHold,
  output logic            lowPowerRequest
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] seenLow;  // cycles the echo has been low while hold is off

  // pins change only at this controller's own clock edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      powerHold       <= 1'b0;
      lowPowerRequest <= 1'b0;
      seenLow         <= 8'h00;
    end else if (sleepReq) begin
      lowPowerRequest <= 1'b1;  // raised with the hold drop
      powerHold       <= 1'b0;
    end else if (offReq) begin
      lowPowerRequest <= 1'b0;
      powerHold       <= 1'b0;
    end else if (wakeReq || (seenLow >= lag && !startEchoOutN)) begin
      powerHold       <= 1'b1;     // hold answers the echo
      lowPowerRequest <= keepLpr;  // dropped in the same edge unless keepLpr
      seenLow         <= 8'h00;
    end else begin
      // software drops the request some time after waking
      lowPowerRequest <= lowPowerRequest & ~(powerHold & ~keepLpr);
      seenLow <= (!startEchoOutN && !powerHold) ? seenLow + 8'h01 : 8'h00;
    end
  end
endmodule // phs_proc_model

/* testbench/phs_sequencer_test.sv */
module phs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import phs_pkg::*;
  logic        clk_sys = 1'b0;  // 25 MHz system clock
  logic        rst = 1'b1;
  phs_bus_t    busReq = '0;
  logic [31:0] readData, d, w;
  logic        startInN = 1'b1, faultIn = 1'b0, keepLpr = 1'b0;
  logic [2:0]  railGood = 3'h0, railShort = 3'h0, req = 3'h0, phaseSel;
  logic        powerHold, lowPowerRequest, resetOutN, startEchoOutN;
  logic        hystEnable;
  logic [7:0]  lag = 8'h00;  // how slowly the processor answers
  phs_rails_t  rails;
  phs_vout_t   voutCfg;
  logic [31:0] seed = 32'h74c8;
  int          numErrors = 0, checked = 0, cyc = 0, n, lows, t2;

  // four cycles per half millisecond keeps the long waits short
  phs_sequencer #(.HALF_MS_CYC_P(4)) phs_sequencer_inst (.clk_sys, .rst,
    .busReq, .readData, .startInN, .powerHold, .lowPowerRequest,
    .resetOutN, .startEchoOutN, .railGood, .railShort, .faultIn, .rails,
    .voutCfg, .phaseSel, .hystEnable);
  phs_proc_model phs_proc_model_inst (.clk_sys, .rst, .sleepReq(req[2]),
    .offReq(req[1]), .wakeReq(req[0]), .keepLpr, .lag, .startEchoOutN,
    .powerHold, .lowPowerRequest);

  always #20 clk_sys = ~clk_sys;
  // power good follows the enables one cycle late
  always @(posedge clk_sys) railGood <= rails.en;
  // hang guard, well above the length of all tests
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      finalReport();
    end
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // voltage word as read back: codes clip at 50 steps, top byte is 0
  function automatic logic [31:0] voutExp(logic [31:0] v);
    logic [31:0] e;
    e = {8'h00, v[23:0]};
    for (int i = 0; i < 3; i++) if (v[6*i +: 6] > 6'h32) e[6*i +: 6] = 6'h32;
    return e;
  endfunction
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      numErrors++;
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk_sys);
    busReq.we <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [3:0] a);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk_sys);
    busReq.re <= 1'b0;
    #1 d = readData;
  endtask
  // one-cycle command to the processor model
  task automatic cmd(logic [2:0] c);
    @(posedge clk_sys);
    req <= c;
    @(posedge clk_sys);
    req <= 3'h0;
    tick(8);
  endtask
  // counts kept-rail drops and forced pwm before reset release
  task automatic waitRst(int lim);
    n = 0;
    lows = 0;
    t2 = 0;
    while (resetOutN !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
      if (rails.en[2] !== 1'b1) t2 = n;
      // the release edge itself may switch the kept rail to forced pwm
      if (resetOutN !== 1'b1 &&
          (rails.en[1] !== 1'b1 || rails.pwm[1] !== 1'b0)) lows++;
    end
    chk("resetOutN", 1, resetOutN);
  endtask
  // start pin held low for 20 cycles, echo checked both ways
  task automatic bootUp();
    @(posedge clk_sys);
    startInN <= 1'b0;
    tick(5);
    chk("echoLow", 0, startEchoOutN);
    tick(15);
    startInN <= 1'b1;
    tick(5);
    chk("echoHigh", 1, startEchoOutN);
    waitRst(3000);
  endtask
  // fault pulse, then wake pulse length and time to restart
  task automatic fault(logic sh);
    @(posedge clk_sys);
    {faultIn, railShort} <= {~sh, 2'b00, sh};
    tick(4);
    {faultIn, railShort} <= 4'h0;
    chk("railsOff", 0, rails.en);
    n = 4;
    lows = 0;
    while (rails.en[0] !== 1'b1 && n < 1500) begin
      @(posedge clk_sys);
      n++;
      if (startEchoOutN === 1'b0) lows++;
    end
    chk("restartTime", 1, n >= 800 && n <= 815);
    $display("fault test done");
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    tick(2);
    rst <= 1'b0;
    #1 chk("rstOut", 0, resetOutN);
    rd(ADDR_SEQ);
    chk("rstDelaySel", 4, d[17:15]);
    chk("wakeDisable", 0, d[18]);
    rd(ADDR_VOUT);
    chk("ssr", 0, d[23:18]);
    rd(ADDR_RAIL);
    chk("disch", 7, d[23:21]);
    chk("phase", 5, phaseSel);
    rd(4'h2);
    chk("unmapped", 0, d);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      w = (i == 0) ? 32'hffffffff : seed;
      wr(ADDR_VOUT, w);
      rd(ADDR_VOUT);
      chk("vout", voutExp(w), d);
      chk("voutCfg", voutExp(w), voutCfg);
    end
    wr(ADDR_SEQ, 32'(SEQ_RST) | 32'h80000);
    tick(2);
    chk("hyst", 1, hystEnable);
    $display("register test done");
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_SEQ, (32'(SEQ_RST) & ~32'h38000) | (s << 15));
      bootUp();
      chk("rstDelay", 1, n-t2 >= (8<<s) && n-t2 <= (8<<s)+11);
      chk("pwmAct", 7, rails.pwm);
      cmd(3'h2);
      chk("offEn", 0, rails.en);
    end
    $display("start test done");
    wr(ADDR_SEQ, 32'(SEQ_RST));
    bootUp();
    cmd(3'h4);
    chk("hibEn", 2, rails.en);
    chk("hibPwm", 0, rails.pwm);
    chk("hibDis", 5, rails.dis);
    cmd(3'h2);
    chk("offEn", 0, rails.en);
    rd(ADDR_STAT);
    chk("offState", 0, d[3:0]);
    bootUp();
    cmd(3'h4);
    cmd(3'h1);
    waitRst(3000);
    chk("keptRail", 0, lows);
    tick(2);
    chk("pwmAfter", 7, rails.pwm);
    $display("hibernate test done");
    cmd(3'h4);
    keepLpr <= 1'b1;
    lag <= 8'h14;
    fault(1'b0);
    chk("wakePulse", 1, lows >= 199 && lows <= 201);
    waitRst(3000);
    rd(ADDR_STAT);
    chk("lowPower", 5, d[3:0]);
    keepLpr <= 1'b0;
    wr(ADDR_RAIL, 32'(RAIL_RST) & ~32'h1c0000);
    fault(1'b1);
    chk("noPulse", 0, lows);
    waitRst(3000);
    wr(ADDR_SEQ, 32'(SEQ_RST) | 32'h40000);
    cmd(3'h4);
    fault(1'b0);
    chk("pulseOff", 0, lows);
    finalReport();
  end
endmodule // phs_sequencer_test
